// >>> inc/aspt_pkg.sv
// Purpose: Shared constants and carriers of the async memory phase sequencer
// Assumes: One system clock; phase counts are in phase units, the wait limit in blocks
// Notes:   Bus widths follow the external memory pins
package aspt_pkg;
   // ***************************************************************
   // Widths and constants
   // ***************************************************************
   localparam int CNT_W = 8;            // Width of each phase count
   localparam int ADDR_W = 21;          // Word address lines
   localparam int BANK_W = 2;           // Bank address lines
   localparam int DATA_W = 16;          // Data lines
   localparam int CS_N = 4;             // Chip selects 5 down to 2
   localparam int CS_SEL_W = 2;         // Index of one chip select
   localparam int BLK_W = 9;            // Wait blocks, up to 256
   localparam int STAT_W = 16;          // Interface status word
   localparam int RATE_BIT = 14;        // Half-rate flag in status word
   localparam logic [15:0] STATUS_ADDR = 16'h1001; // Status word address
   localparam logic [4:0] WAIT_UNIT = 5'h10;       // Phase units per block
   localparam logic [3:0] WAIT_RELEASE = 4'h4;     // Units after wait drops
   localparam logic [BLK_W-1:0] WAIT_BLK_MAX = 9'h100; // Most blocks, 256
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   // Programmable phase counts in phase units; max_wait_limit in 16-unit wait blocks
   typedef struct packed {
      logic [CNT_W-1:0] bus_turnaround_cycles;
      logic [CNT_W-1:0] read_setup_cycles;
      logic [CNT_W-1:0] read_strobe_cycles;
      logic [CNT_W-1:0] read_hold_cycles;
      logic [CNT_W-1:0] write_setup_cycles;
      logic [CNT_W-1:0] write_strobe_cycles;
      logic [CNT_W-1:0] write_hold_cycles;
      logic [CNT_W-1:0] max_wait_limit;
   } aspt_cfg_t;

   // One access request from the user side
   typedef struct packed {
      logic write;
      logic [CS_SEL_W-1:0] cs_sel;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } aspt_req_t;
endpackage : aspt_pkg

// >>> src/aspt_phase_tick.sv
// Purpose: Phase-unit enable: every clock, or every second clock
// Assumes: half_rate_in is quasi-static
// Notes:   The enable is a one-cycle pulse in half rate and held high in full rate, never a derived clock
`timescale 1ns/100ps
module aspt_phase_tick (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic half_rate_in,
   output logic tick_out
);
   logic phase;

   // Toggle divider; in full rate every edge is a phase unit
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         phase <= 1'b0;
      end else begin
         phase <= half_rate_in ? ~phase : 1'b0;
      end
   end

   assign tick_out = !half_rate_in || phase;

   // ***************************************************************
   // Checks
   // ***************************************************************
   chk_half_rate_gap: assert property (@(posedge ref_clk_in)
      disable iff (!arst_n_in)
      (half_rate_in && $past(half_rate_in) && tick_out) ##1 half_rate_in
         |-> !tick_out)
      else $error("half rate tick not spaced by two clocks");
endmodule : aspt_phase_tick

// >>> src/aspt_wait_track.sv
// Purpose: Extended wait tracking: 16-unit blocks, release and timeout
// Assumes: Wait input is synchronous; started on the last strobe unit
// Notes:   Counts one block at start, one more every 16 phase units while wait is held
`timescale 1ns/100ps
module aspt_wait_track #(
   parameter int RELEASE_UNITS = 4
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic tick_in,
   input wire logic start_in,
   input wire logic active_in,
   input wire logic wait_in,
   input wire logic [aspt_pkg::CNT_W-1:0] max_wait_in,
   output logic done_out,
   output logic timeout_out,
   output logic [aspt_pkg::BLK_W-1:0] blocks_out
);
   logic [4:0] unit;
   logic [3:0] rel;
   logic releasing;
   logic block_end;

   // The release count loads as units minus two; below two it would wrap
   if (RELEASE_UNITS < 2 || RELEASE_UNITS > 15) begin : g_bad_release
      $error("RELEASE_UNITS out of range");
   end

   assign block_end = active_in && tick_in &&
                      (unit == aspt_pkg::WAIT_UNIT - 5'h01);
   // A limit of zero ends the wait at the first block boundary
   assign timeout_out = block_end && !done_out &&
                        (blocks_out >= {1'b0, max_wait_in});
   assign done_out = active_in && tick_in && releasing && (rel == 4'h0);

   // Unit and block counting, each block is 16 phase units
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         unit <= 5'h00;
         blocks_out <= '0;
      end else if (start_in) begin
         unit <= 5'h00;
         blocks_out <= 9'h001;
      end else if (active_in && tick_in) begin
         unit <= block_end ? 5'h00 : unit + 5'h01;
         if (block_end && wait_in && blocks_out != aspt_pkg::WAIT_BLK_MAX)
            blocks_out <= blocks_out + 9'h001;
      end
   end

   // Release: strobe ends a fixed number of units after wait drops
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         releasing <= 1'b0;
         rel <= 4'h0;
      end else if (start_in) begin
         releasing <= 1'b0;
      end else if (active_in && tick_in) begin
         if (!releasing && !wait_in) begin
            releasing <= 1'b1;
            rel <= 4'(RELEASE_UNITS - 2);
         end else if (releasing && rel != 4'h0) begin
            rel <= rel - 4'h1;
         end
      end
   end
endmodule : aspt_wait_track

// >>> src/aspt_core.sv
// Purpose: Phase sequencer for async SRAM / NOR memory accesses
// Assumes: Config, mode and request inputs synchronous to ref_clk_in
// Notes:   All pin outputs lag the state by one clock, equally
`timescale 1ns/100ps
module aspt_core (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire aspt_pkg::aspt_cfg_t cfg_in,
   input wire logic half_rate_in,
   input wire logic extended_wait_enable_in,
   input wire logic sel_strobe_in,
   input wire logic req_valid_in,
   input wire aspt_pkg::aspt_req_t req_in,
   output logic req_ready_out,
   output logic [aspt_pkg::DATA_W-1:0] rd_data_out,
   output logic rd_valid_out,
   output logic wr_done_out,
   output logic busy_out,
   output logic wait_timeout_out,
   output logic [aspt_pkg::BLK_W-1:0] requested_wait_count_out,
   output logic [aspt_pkg::STAT_W-1:0] if_status_out,
   output logic [aspt_pkg::CS_N-1:0] mem_chip_sel_n_out,
   output logic mem_out_en_n_out,
   output logic mem_wr_en_n_out,
   output logic [aspt_pkg::ADDR_W-1:0] mem_addr_out,
   output logic [aspt_pkg::BANK_W-1:0] mem_bank_addr_out,
   output logic [aspt_pkg::DATA_W-1:0] mem_data_out,
   output logic mem_data_oe_n_out,
   input wire logic [aspt_pkg::DATA_W-1:0] mem_data_in,
   input wire logic mem_wait_in
);
   typedef enum logic [2:0] {
      S_IDLE, S_SETUP, S_STROBE, S_EXTEND, S_HOLD, S_TURN
   } aspt_state_t;

   aspt_state_t state;
   aspt_pkg::aspt_req_t req;
   logic [aspt_pkg::CNT_W-1:0] cnt;
   logic pend;
   logic tick;
   logic accept;
   logic wait_seen;
   logic wt_start;
   logic wt_done;
   logic wt_timeout;
   logic [aspt_pkg::BLK_W-1:0] wt_blocks;
   logic strobe_end;
   logic leave_strobe;
   logic strobe_on;
   logic phase_on;
   logic cs_on;
   logic [aspt_pkg::CNT_W-1:0] setup_m1;
   logic [aspt_pkg::CNT_W-1:0] strobe_m1;
   logic [aspt_pkg::CNT_W-1:0] hold_m1;
   logic [aspt_pkg::CNT_W-1:0] turn_m1;
   logic [aspt_pkg::CNT_W-1:0] strobe_units;

   // A zero count would leave no unit for the pins to settle, so it
   // acts as one unit; each phase then lasts cnt+1 ticks after load
   function automatic logic [aspt_pkg::CNT_W-1:0] cnt_load(
      input logic [aspt_pkg::CNT_W-1:0] v);
      cnt_load = (v == aspt_pkg::CNT_ZERO) ? aspt_pkg::CNT_ZERO :
                 v - aspt_pkg::CNT_ONE;
   endfunction : cnt_load

   // ***************************************************************
   // Phase-unit enable and wait tracking
   // ***************************************************************
   aspt_phase_tick u_tick (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .half_rate_in(half_rate_in),
      .tick_out(tick)
   );

   aspt_wait_track #(
      .RELEASE_UNITS(int'(aspt_pkg::WAIT_RELEASE))
   ) u_wait (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .tick_in(tick),
      .start_in(wt_start),
      .active_in(state == S_EXTEND),
      .wait_in(wait_seen),
      .max_wait_in(cfg_in.max_wait_limit),
      .done_out(wt_done),
      .timeout_out(wt_timeout),
      .blocks_out(wt_blocks)
   );

   // ***************************************************************
   // Phase counts for the access in flight
   // ***************************************************************
   // Read and write counts are selected per access direction
   always_comb begin
      if (req.write) begin
         setup_m1 = cnt_load(cfg_in.write_setup_cycles);
         strobe_m1 = cnt_load(cfg_in.write_strobe_cycles);
         hold_m1 = cnt_load(cfg_in.write_hold_cycles);
      end else begin
         setup_m1 = cnt_load(cfg_in.read_setup_cycles);
         strobe_m1 = cnt_load(cfg_in.read_strobe_cycles);
         hold_m1 = cnt_load(cfg_in.read_hold_cycles);
      end
      turn_m1 = cnt_load(cfg_in.bus_turnaround_cycles);
   end

   // Wait is masked when extended wait is off
   assign wait_seen = extended_wait_enable_in && mem_wait_in;
   assign strobe_end = tick && (state == S_STROBE) &&
                       (cnt == aspt_pkg::CNT_ZERO);
   assign wt_start = strobe_end && wait_seen;
   assign leave_strobe = (strobe_end && !wait_seen) ||
                         (state == S_EXTEND && (wt_done || wt_timeout));
   assign accept = req_valid_in && req_ready_out;

   // ***************************************************************
   // Request intake
   // ***************************************************************
   // One request is latched; ready drops until the sequencer is idle
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         req <= '0;
         pend <= 1'b0;
         req_ready_out <= 1'b1;
      end else begin
         if (accept) begin
            req <= req_in;
            pend <= 1'b1;
            req_ready_out <= 1'b0;
         end else begin
            if (tick && state == S_IDLE)
               pend <= 1'b0;
            if (state == S_IDLE && !pend)
               req_ready_out <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // Phase sequencer
   // ***************************************************************
   // Moves only on phase-unit ticks, so half rate doubles every phase
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= S_IDLE;
         cnt <= '0;
      end else if (tick) begin
         unique case (state)
            S_IDLE: begin
               if (pend) begin
                  state <= S_SETUP;
                  cnt <= setup_m1;
               end
            end
            S_SETUP: begin
               if (cnt == aspt_pkg::CNT_ZERO) begin
                  state <= S_STROBE;
                  cnt <= strobe_m1;
               end else begin
                  cnt <= cnt - aspt_pkg::CNT_ONE;
               end
            end
            S_STROBE: begin
               if (cnt != aspt_pkg::CNT_ZERO) begin
                  cnt <= cnt - aspt_pkg::CNT_ONE;
               end else if (wait_seen) begin
                  state <= S_EXTEND;
               end else begin
                  state <= S_HOLD;
                  cnt <= hold_m1;
               end
            end
            S_EXTEND: begin
               // Timeout takes the same exit as a released wait
               if (wt_done || wt_timeout) begin
                  state <= S_HOLD;
                  cnt <= hold_m1;
               end
            end
            S_HOLD: begin
               if (cnt == aspt_pkg::CNT_ZERO) begin
                  state <= S_TURN;
                  cnt <= turn_m1;
               end else begin
                  cnt <= cnt - aspt_pkg::CNT_ONE;
               end
            end
            S_TURN: begin
               if (cnt == aspt_pkg::CNT_ZERO)
                  state <= S_IDLE;
               else
                  cnt <= cnt - aspt_pkg::CNT_ONE;
            end
         endcase
      end
   end

   // ***************************************************************
   // Pin drive
   // ***************************************************************
   assign strobe_on = (state == S_STROBE) || (state == S_EXTEND);
   assign phase_on = (state == S_SETUP) || strobe_on || (state == S_HOLD);
   assign cs_on = sel_strobe_in ? strobe_on : phase_on;

   // Strobes and select are registered from state, so all pins share
   // one clock of latency and relative phase lengths stay exact
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mem_out_en_n_out <= 1'b1;
         mem_wr_en_n_out <= 1'b1;
      end else begin
         mem_out_en_n_out <= !(strobe_on && !req.write);
         mem_wr_en_n_out <= !(strobe_on && req.write);
      end
   end

   // One select per chip; only the addressed one drops
   for (genvar i = 0; i < aspt_pkg::CS_N; i++) begin : g_cs
      always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
         if (!arst_n_in)
            mem_chip_sel_n_out[i] <= 1'b1;
         else
            mem_chip_sel_n_out[i] <= !(cs_on &&
               req.cs_sel == aspt_pkg::CS_SEL_W'(i));
      end
   end

   // Address, bank and data stand through setup, strobe and hold; the
   // address keeps its last value afterwards to spare pin toggling
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mem_addr_out <= '0;
         mem_bank_addr_out <= '0;
         mem_data_out <= '0;
         mem_data_oe_n_out <= 1'b1;
      end else begin
         if (phase_on) begin
            mem_addr_out <= req.addr;
            mem_bank_addr_out <= req.bank;
            mem_data_out <= req.wdata;
         end
         mem_data_oe_n_out <= !(phase_on && req.write);
      end
   end

   // ***************************************************************
   // User-side results and status
   // ***************************************************************
   // Read data is taken on the last strobe unit, output-enable still low
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_data_out <= '0;
         rd_valid_out <= 1'b0;
         wr_done_out <= 1'b0;
      end else begin
         rd_valid_out <= tick && leave_strobe && !req.write;
         wr_done_out <= tick && leave_strobe && req.write;
         if (tick && leave_strobe && !req.write)
            rd_data_out <= mem_data_in;
      end
   end

   // Timeout flag lives until the next access; a new timeout wins
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wait_timeout_out <= 1'b0;
         requested_wait_count_out <= '0;
         busy_out <= 1'b0;
         if_status_out <= '0;
      end else begin
         if (wt_timeout && state == S_EXTEND)
            wait_timeout_out <= 1'b1;
         else if (accept)
            wait_timeout_out <= 1'b0;
         if (wt_start)
            requested_wait_count_out <= '0;
         else if (state == S_EXTEND)
            requested_wait_count_out <= wt_blocks;
         busy_out <= (state != S_IDLE) || pend;
         if_status_out <= '0;
         if_status_out[aspt_pkg::RATE_BIT] <= half_rate_in;
      end
   end

   // Strobe phase unit counter, read only by the checks below
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in)
         strobe_units <= '0;
      else if (state != S_STROBE)
         strobe_units <= '0;
      else if (tick)
         strobe_units <= strobe_units + aspt_pkg::CNT_ONE;
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   chk_status_rate: assert property (@(posedge ref_clk_in)
      disable iff (!arst_n_in)
      $stable(half_rate_in) |->
         if_status_out[aspt_pkg::RATE_BIT] == half_rate_in)
      else $error("status rate bit disagrees with mode");

   chk_turn_follows: assert property (@(posedge ref_clk_in)
      disable iff (!arst_n_in)
      (tick && state == S_HOLD && cnt == aspt_pkg::CNT_ZERO)
         |=> state == S_TURN && cnt == $past(turn_m1))
      else $error("no turnaround after hold");

   chk_strobe_length: assert property (@(posedge ref_clk_in)
      disable iff (!arst_n_in)
      (strobe_end && !wait_seen) |->
         strobe_units == strobe_m1)
      else $error("strobe phase unit count wrong");

   chk_wait_ignored: assert property (@(posedge ref_clk_in)
      disable iff (!arst_n_in)
      (strobe_end && !extended_wait_enable_in) |=> state == S_HOLD)
      else $error("wait honoured with extended wait off");

   chk_cs_with_strobe: assert property (@(posedge ref_clk_in)
      disable iff (!arst_n_in)
      (sel_strobe_in && $past(sel_strobe_in)) |->
         ((&mem_chip_sel_n_out) ==
          (mem_out_en_n_out && mem_wr_en_n_out)))
      else $error("chip select not aligned with strobe");

   chk_data_driven: assert property (@(posedge ref_clk_in)
      disable iff (!arst_n_in)
      (!mem_wr_en_n_out) |-> !mem_data_oe_n_out ##1
         (!mem_data_oe_n_out || mem_wr_en_n_out))
      else $error("write data released during write strobe");

   chk_wait_release: assert property (@(posedge ref_clk_in)
      disable iff (!arst_n_in)
      (state == S_EXTEND && tick && !wait_seen && $past(wait_seen))
         |-> ##[1:10] state == S_HOLD)
      else $error("strobe not released after wait dropped");

   chk_timeout_hold: assert property (@(posedge ref_clk_in)
      disable iff (!arst_n_in)
      (state == S_EXTEND && wt_timeout) |=>
         state == S_HOLD ##1 wait_timeout_out)
      else $error("timeout did not end strobe into hold");

   chk_strobes_apart: assert property (@(posedge ref_clk_in)
      disable iff (!arst_n_in)
      !(!mem_out_en_n_out && !mem_wr_en_n_out))
      else $error("read and write strobes both low");
endmodule : aspt_core

// >>> tb/aspt_mem_model.sv
// Purpose: Async memory model facing the phase sequencer
// Assumes: Wait rises as a strobe falls and stays up wait_len_in clocks
// Notes:   A released data bus shows the inverse of the last read word
`timescale 1ns/100ps
module aspt_mem_model (
   input wire logic ref_clk_in,
   input wire logic [3:0] cs_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] data_in,
   input wire logic [7:0] wait_len_in,
   output logic [15:0] data_out,
   output logic wait_out
);
   logic [15:0] mem [16];
   logic [15:0] last;
   logic strb_q;
   logic we_q;
   logic [7:0] left;
   // Read drive; the inverse keeps stale data from passing as a match
   assign data_out = (!oe_n_in && !(&cs_n_in)) ? mem[addr_in] : ~last;
   initial begin
      wait_out = 1'b0;
      last = 16'h0000;
      strb_q = 1'b1;
      we_q = 1'b1;
      left = 8'h00;
   end
   // Store on write strobe rise; raise wait early in the strobe
   always @(posedge ref_clk_in) begin
      strb_q <= oe_n_in & we_n_in;
      we_q <= we_n_in;
      if (!oe_n_in) last <= mem[addr_in];
      if (we_n_in && !we_q) mem[addr_in] <= data_in;
      if (!(oe_n_in & we_n_in) && strb_q && wait_len_in != 8'h00) begin
         wait_out <= 1'b1;
         left <= wait_len_in;
      end else if (left > 8'h01) left <= left - 8'h01;
      else begin
         wait_out <= 1'b0;
         left <= 8'h00;
      end
   end
endmodule : aspt_mem_model

// >>> tb/aspt_core_test.sv
// Purpose: Self-checking bench of the phase sequencer
// Assumes: 250 MHz clock; memory model on the pin side
// Notes:   Pin phase widths are measured in clocks and compared
`timescale 1ns/100ps
module aspt_core_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   aspt_pkg::aspt_cfg_t cfg;
   aspt_pkg::aspt_req_t req;
   logic half, ew, ss, vld, rdy, rdv, busy, tmo, oe_n, we_n, doe_n, wt, wd;
   logic [7:0] wlen;
   logic [15:0] rdat, md, mi, stat, rd_last;
   logic [3:0] cs_n, cs_s;
   logic [20:0] ma, ma_s;
   logic [1:0] ba, ba_s;
   logic [8:0] rwc;
   int num_errors = 0;
   int samples_checked = 0;
   int sw, sw_c, cs_w, cs_c, doe_w, doe_c, rel_w, rel_c, gap_w, gap_c;
   int wd_n = 0;
   always #2 clk = ~clk;
   aspt_core dut (.ref_clk_in(clk), .arst_n_in(rst_n), .cfg_in(cfg),
      .half_rate_in(half), .extended_wait_enable_in(ew),
      .sel_strobe_in(ss), .req_valid_in(vld), .req_in(req),
      .req_ready_out(rdy), .rd_data_out(rdat), .rd_valid_out(rdv),
      .wr_done_out(wd), .busy_out(busy), .wait_timeout_out(tmo),
      .requested_wait_count_out(rwc), .if_status_out(stat),
      .mem_chip_sel_n_out(cs_n), .mem_out_en_n_out(oe_n),
      .mem_wr_en_n_out(we_n), .mem_addr_out(ma), .mem_bank_addr_out(ba),
      .mem_data_out(md), .mem_data_oe_n_out(doe_n), .mem_data_in(mi),
      .mem_wait_in(wt));
   aspt_mem_model mem (.ref_clk_in(clk), .cs_n_in(cs_n), .oe_n_in(oe_n),
      .we_n_in(we_n), .addr_in(ma[3:0]), .data_in(md), .wait_len_in(wlen),
      .data_out(mi), .wait_out(wt));
   // Low widths and the select-high gap latched as each phase ends; sampled before edge updates
   always @(posedge clk) begin
      if ((oe_n & we_n) && sw_c > 0) sw = sw_c;
      if ((oe_n & we_n) && sw_c > 0) rel_w = rel_c;
      sw_c = (oe_n & we_n) ? 0 : sw_c + 1;
      rel_c = wt ? 0 : rel_c + 1;
      if ((&cs_n) && cs_c > 0) cs_w = cs_c;
      if (!(&cs_n) && gap_c > 0) gap_w = gap_c;
      // Address, bank and select as the select first drops
      if (!(&cs_n) && gap_c > 0) ba_s = ba;
      if (!(&cs_n) && gap_c > 0) ma_s = ma;
      if (!(&cs_n) && gap_c > 0) cs_s = cs_n;
      if (wd) wd_n++;
      cs_c = (&cs_n) ? 0 : cs_c + 1;
      gap_c = (&cs_n) ? gap_c + 1 : 0;
      if (doe_n && doe_c > 0) doe_w = doe_c;
      doe_c = doe_n ? 0 : doe_c + 1;
      if (rdv) rd_last = rdat;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Holds the request until ready is seen, then waits for idle
   task automatic acc(input logic w, input logic [20:0] a,
                      input logic [15:0] d);
      int n;
      n = 0;
      vld <= 1'b1;
      req <= '{write: w, cs_sel: 2'h1, bank: a[1:0], addr: a, wdata: d};
      do @(posedge clk); while (rdy !== 1'b1);
      vld <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) num_errors++;
   endtask : acc
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // Hang guard, well beyond the few hundred clocks the tests need
   initial begin
      #100000;
      num_errors++;
      give_verdict();
   end
   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      cfg <= '{8'h02, 8'h02, 8'h06, 8'h03, 8'h03, 8'h06, 8'h02, 8'h04};
      {half, ew, ss, vld, wlen} <= 12'h000;
      req <= '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      acc(1'b1, 21'h00005, 16'ha55a);
      chk(sw, 6); // Write strobe width
      chk(cs_w, 11); // Write cycle under select
      chk(doe_w, 11); // Data setup plus strobe plus hold
      chk(cs_s, 4'hd); // Only the addressed select drops
      chk(ma_s, 21'h00005); // Address out from setup start
      chk(ba_s, 2'h1); // Bank out from setup start
      acc(1'b0, 21'h00005, 16'h0000);
      chk(sw, 6); // Read strobe width
      chk(cs_w, 11); // Read cycle under select
      chk(gap_w >= 2, 1); // Idle gap between accesses
      chk(rd_last, 16'ha55a); // Data read back
      chk(ma, 21'h00005); // Address held after strobe
      $display("test full rate done");
      ss <= 1'b1;
      acc(1'b0, 21'h00005, 16'h0000);
      chk(cs_w, 6); // Select only with strobe
      ss <= 1'b0;
      half <= 1'b1;
      repeat (3) @(posedge clk);
      chk(stat[14], 1); // Half-rate flag
      acc(1'b1, 21'h00006, 16'h1234);
      chk(sw, 12); // Strobe doubled
      chk(cs_w, 22); // Cycle doubled
      chk(ma_s, 21'h00006); // Address out from setup start
      chk(ba_s, 2'h2); // Bank out from setup start
      half <= 1'b0;
      $display("test select and rate done");
      wlen <= 8'h20;
      acc(1'b0, 21'h00006, 16'h0000);
      chk(sw, 6); // Wait ignored when disabled
      chk(rd_last, 16'h1234); // Half-rate write stored
      chk(stat[14], 0); // Full-rate flag
      repeat (40) @(posedge clk);
      ew <= 1'b1;
      acc(1'b0, 21'h00005, 16'h0000);
      chk(rel_w >= 3 && rel_w <= 5, 1); // Release after wait drops
      chk(sw > 6 && tmo === 1'b0, 1); // Read strobe stretched
      // 32 clocks of wait: the first block plus one more 16-unit block
      chk(rwc, 9'h002); // Wait blocks counted
      chk(ba_s, 2'h1); // Read bank out before output-enable
      acc(1'b1, 21'h00007, 16'hbeef);
      chk(rel_w >= 3 && rel_w <= 5, 1); // Release after wait drops
      chk(sw > 6, 1); // Write strobe stretched
      cfg.max_wait_limit <= 8'h01;
      wlen <= 8'hff;
      acc(1'b0, 21'h00007, 16'h0000);
      chk(tmo, 1); // Timeout flagged
      chk(sw < 54, 1); // Strobe cut short
      chk(cs_w - sw, 5); // Normal setup and hold kept
      chk(rwc, 9'h001); // Wait bounded by the limit
      chk(wd_n, 3); // One done pulse per write
      $display("test extended wait done");
      give_verdict();
   end
endmodule : aspt_core_test
